// File: ppio_map.svh
`ifndef PPIO_MAP_SVH
`define PPIO_MAP_SVH
// clock rate and the position-code setup time ahead of start
`define PPIO_CLK_KHZ   250000
`define PPIO_SETUP_MS  6
`define PPIO_HOLD_W    21
// register port geometry
`define PPIO_AW        4
`define PPIO_DW        32
// register offsets (byte addresses)
`define PPIO_REG_CTRL  4'h0
`define PPIO_REG_STAT  4'h4
`define PPIO_REG_POS   4'h8
// field positions and reset values
`define PPIO_STAT_VIOL 8
`define PPIO_CTRL_RST  2'h0
`define PPIO_POS_RST   8'h00
`define PPIO_ZERO      32'h0000_0000
`endif

// File: ppio_pkg.sv
package ppio_pkg;

   // positioning sequence states
   typedef enum logic [1:0] {
      PPIO_IDLE,
      PPIO_MOVE,
      PPIO_HOME
   } ppio_state_type;

   // 8-bit position code, weights 1 .. 128
   typedef struct packed {
      logic cmd_pos_bit7;
      logic cmd_pos_bit6;
      logic cmd_pos_bit5;
      logic cmd_pos_bit4;
      logic cmd_pos_bit3;
      logic cmd_pos_bit2;
      logic cmd_pos_bit1;
      logic cmd_pos_bit0;
   } ppio_code_type;

   // discrete inputs from the plc
   typedef struct packed {
      ppio_code_type cmd_pos;
      logic          motion_start_in;
      logic          home_in;
      logic          alarm_clear_in;
      logic          servo_enable_in;
      logic          pause_n_in;
      logic          brake_release_in;
      logic          mode_select_in;
   } ppio_plc_in_type;

   // status reported by the motion core
   typedef struct packed {
      logic moving;
      logic reached;
      logic in_band;
      logic in_zone;
      logic home_finished;
      logic ctrl_ok;
      logic estop;
      logic alarm_raise;
      logic torque_over;
      logic in_check;
      logic current_hit;
   } ppio_core_sts_type;

   // commands towards the motion core
   typedef struct packed {
      logic          move_req;
      logic          home_req;
      logic          alarm_reset;
      logic          servo_on;
      logic          decel_stop;
      logic          brake_release;
      logic          manual_mode;
      ppio_code_type target;
   } ppio_core_cmd_type;

   // control register: variant output enables
   typedef struct packed {
      logic trq_en;
      logic load_en;
   } ppio_ctrl_type;

   // status register layout, low bits of the word
   typedef struct packed {
      logic           setup_viol;
      logic           moving;
      logic           ready;
      logic           in_position;
      logic           zone_armed;
      logic           alarm;
      logic           home_done;
      ppio_state_type state;
   } ppio_stat_type;

endpackage

// File: ppio_in_sync.sv
module ppio_in_sync
   import ppio_pkg::*;
(
   input  wire logic            clk,
   input  wire logic            nrst,
   input  wire ppio_plc_in_type raw,
   output ppio_plc_in_type      lvl,
   output ppio_plc_in_type      rise
);

   ppio_plc_in_type meta_ff;   // first stage, read only by stage two
   ppio_plc_in_type sync_ff;   // settled level
   ppio_plc_in_type last_ff;   // previous settled level

   // two-stage synchroniser plus one stage of history
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         meta_ff <= '0;
         sync_ff <= '0;
         last_ff <= '0;
      end else begin
         meta_ff <= raw;
         sync_ff <= meta_ff;
         last_ff <= sync_ff;
      end
   end

   // edges come from settled stages only, so each lasts one cycle
   assign lvl  = sync_ff;
   assign rise = sync_ff & ~last_ff;

endmodule

// File: ppio_positioner.sv
// Operation
// R1: host gives 8-bit target code, weights 1..128
// R2: host holds code 6 ms before start
// R3: start rising edge begins move to target
// R4: home rising edge begins home return
// R5: alarm clear rising edge resets alarm
// R6: servo follows servo enable level
// R7: pause low decelerates actuator to stop
// R8: brake release input forces brake open
// R9: mode select level picks auto or manual
// R10: completed code shows reached position index
// R11: completed code clears on next start
// R12: zone only after move command, inside range
// R13: mode status low auto, high manual
// R14: home done low from reset, set after homing
// R15: in-position once target reached within band
// R16: ready when servo on and controller able
// R17: estop status low while stop actuated
// R18: alarm output high normally, low on alarm
// R19: load judgment: torque over inside check range
// R20: torque level when current hits threshold
// R21: moving high while travelling, else low
// R22: inputs synchronised, each edge acted once
//
// The strobed register port and the register addresses were left to the implementer.
`include "ppio_map.svh"

module ppio_positioner
   import ppio_pkg::*;
#(
   parameter int SETUP_CYCLES = `PPIO_SETUP_MS * `PPIO_CLK_KHZ
)
(
   input  wire logic                clk,
   input  wire logic                nrst,
   input  wire ppio_plc_in_type     plc_in,
   input  wire ppio_core_sts_type   core_sts,
   input  wire logic [`PPIO_AW-1:0] reg_addr,
   input  wire logic [`PPIO_DW-1:0] reg_wdata,
   input  wire logic                reg_wr,
   input  wire logic                reg_rd,
   output logic [`PPIO_DW-1:0]      reg_rdata,
   output ppio_core_cmd_type        core_cmd,
   output ppio_code_type            done_pos_out,
   output logic                     zone_flag_out,
   output logic                     mode_status_out,
   output logic                     home_done_out,
   output logic                     in_position_out,
   output logic                     ready_out,
   output logic                     estop_n_out,
   output logic                     alarm_n_out,
   output logic                     load_judge_out,
   output logic                     torque_level_out,
   output logic                     moving_out
);

   // true when the port address selects the given register
   function automatic logic reg_hit(input logic [`PPIO_AW-1:0] a, off);
      reg_hit = (a == off);
   endfunction

   // settled input levels and one-cycle rising edges
   ppio_plc_in_type   lvl;
   ppio_plc_in_type   rise;
   // sequence and status flops
   ppio_state_type    state_ff;
   ppio_state_type    nxt_state;
   logic              alarm_ff;       // alarm latched
   logic              nxt_alarm;
   logic              zone_armed_ff;  // a move has been commanded
   logic              home_done_ff;
   logic              in_pos_ff;
   logic              setup_viol_ff;  // code changed too close to start
   ppio_code_type     target_ff;      // code taken at the start edge
   ppio_code_type     code_last_ff;   // previous settled code
   logic [`PPIO_HOLD_W-1:0] hold_cnt_ff; // cycles the code stood still
   ppio_ctrl_type     ctrl_ff;
   ppio_core_cmd_type cmd_ff;
   ppio_code_type     done_ff;
   // decisions made this cycle
   logic              able;       // servo on, core able, no alarm
   logic              start_ok;   // start edge accepted
   logic              home_ok;    // home edge accepted
   logic              move_done;  // target reached within band
   logic              home_fin;   // home return finished
   logic              hold_short; // code younger than setup time

   // every discrete input passes two flops before it is used
   ppio_in_sync u_sync (
      .clk  (clk),
      .nrst (nrst),
      .raw  (plc_in),
      .lvl  (lvl),
      .rise (rise)
   );

   // acceptance: start needs auto mode and no pause in force
   assign able      = lvl.servo_enable_in && core_sts.ctrl_ok
                      && !alarm_ff;
   assign start_ok  = rise.motion_start_in && able          // [R3] [R22]
                      && !lvl.mode_select_in && lvl.pause_n_in
                      && (state_ff != PPIO_HOME);
   assign home_ok   = rise.home_in && able                  // [R4] [R22]
                      && (state_ff == PPIO_IDLE);
   // the core's reached flag is stale while the request is in flight
   assign move_done = (state_ff == PPIO_MOVE) && core_sts.reached
                      && core_sts.in_band && !cmd_ff.move_req;
   assign home_fin  = (state_ff == PPIO_HOME) && core_sts.home_finished;
   // a code that changes in the start cycle is a slip as well
   assign hold_short = (lvl.cmd_pos != code_last_ff)
                       || (hold_cnt_ff < SETUP_CYCLES[`PPIO_HOLD_W-1:0]);

   // sequence state: a raised alarm or servo loss aborts motion
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         PPIO_IDLE: begin
            if (start_ok) begin
               nxt_state = PPIO_MOVE;                       // [R3]
            end else if (home_ok) begin
               nxt_state = PPIO_HOME;                       // [R4]
            end
         end
         PPIO_MOVE: begin
            if (move_done && !start_ok) begin
               nxt_state = PPIO_IDLE;
            end
         end
         PPIO_HOME: begin
            if (home_fin) begin
               nxt_state = PPIO_IDLE;
            end
         end
         default: nxt_state = PPIO_IDLE;
      endcase
      if (nxt_alarm || !lvl.servo_enable_in) begin
         nxt_state = PPIO_IDLE;
      end
   end
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state_ff <= PPIO_IDLE;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // alarm latch: a new alarm wins over a clear in the same cycle
   always_comb begin
      nxt_alarm = alarm_ff;
      if (rise.alarm_clear_in) begin
         nxt_alarm = 1'b0;                                  // [R5]
      end
      if (core_sts.alarm_raise) begin
         nxt_alarm = 1'b1;                                  // [R18]
      end
   end
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         alarm_ff    <= 1'b0;
         alarm_n_out <= 1'b1;
      end else begin
         alarm_ff    <= nxt_alarm;
         alarm_n_out <= !nxt_alarm;                         // [R18]
      end
   end

   // target capture at the accepted start edge
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         target_ff <= `PPIO_POS_RST;
      end else if (start_ok) begin
         target_ff <= lvl.cmd_pos;                          // [R1] [R3]
      end
   end
   // completed-position code: cleared by start, set on completion
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         done_ff <= `PPIO_POS_RST;
      end else if (start_ok) begin
         done_ff <= `PPIO_POS_RST;                          // [R11]
      end else if (move_done) begin
         done_ff <= target_ff;                              // [R10]
      end
   end
   // in-position flag drops at an accepted start or home edge
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         in_pos_ff <= 1'b0;
      end else if (start_ok || home_ok) begin
         in_pos_ff <= 1'b0;
      end else if (move_done) begin
         in_pos_ff <= 1'b1;                                 // [R15]
      end
   end
   // zone output is armed by the first move command and stays armed
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         zone_armed_ff <= 1'b0;
      end else if (start_ok) begin
         zone_armed_ff <= 1'b1;                             // [R12]
      end
   end
   // home done: low after reset, cleared when homing restarts
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         home_done_ff <= 1'b0;                              // [R14]
      end else if (home_fin) begin
         home_done_ff <= 1'b1;                              // [R14]
      end else if (home_ok) begin
         home_done_ff <= 1'b0;
      end
   end

   // age of the position code, saturating at the setup time
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         code_last_ff <= `PPIO_POS_RST;
         hold_cnt_ff  <= '0;
      end else begin
         code_last_ff <= lvl.cmd_pos;
         if (lvl.cmd_pos != code_last_ff) begin
            hold_cnt_ff <= '0;
         end else if (hold_short) begin
            hold_cnt_ff <= hold_cnt_ff + 1'b1;
         end
      end
   end

   // host slip on setup time is only logged; the move still runs,
   // software clears by writing one, and a new slip wins the cycle
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         setup_viol_ff <= 1'b0;
      end else if (start_ok && hold_short) begin
         setup_viol_ff <= 1'b1;                             // [R2]
      end else if (reg_wr && reg_hit(reg_addr, `PPIO_REG_STAT)
                   && reg_wdata[`PPIO_STAT_VIOL]) begin
         setup_viol_ff <= 1'b0;
      end
   end

   // control register: variant outputs off until software enables
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ctrl_ff <= `PPIO_CTRL_RST;
      end else if (reg_wr && reg_hit(reg_addr, `PPIO_REG_CTRL)) begin
         ctrl_ff <= reg_wdata[$bits(ppio_ctrl_type)-1:0];
      end
   end

   // read data one cycle after the strobe, zero when unmapped
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         reg_rdata <= `PPIO_ZERO;
      end else if (reg_rd && reg_hit(reg_addr, `PPIO_REG_CTRL)) begin
         reg_rdata <= `PPIO_DW'(ctrl_ff);
      end else if (reg_rd && reg_hit(reg_addr, `PPIO_REG_STAT)) begin
         reg_rdata <= `PPIO_DW'({setup_viol_ff, moving_out,
                                 ready_out, in_pos_ff,
                                 zone_armed_ff, alarm_ff,
                                 home_done_ff, state_ff});
      end else if (reg_rd && reg_hit(reg_addr, `PPIO_REG_POS)) begin
         reg_rdata <= `PPIO_DW'({done_ff, target_ff});
      end else begin
         reg_rdata <= `PPIO_ZERO;                // idle or unmapped
      end
   end

   // commands to the motion core: pulses for edges, levels follow
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cmd_ff <= '0;
      end else begin
         cmd_ff.move_req      <= start_ok;                  // [R3]
         cmd_ff.home_req      <= home_ok;                   // [R4]
         cmd_ff.alarm_reset   <= rise.alarm_clear_in;       // [R5]
         cmd_ff.servo_on      <= lvl.servo_enable_in;       // [R6]
         cmd_ff.decel_stop    <= !lvl.pause_n_in;           // [R7]
         cmd_ff.brake_release <= lvl.brake_release_in;      // [R8]
         cmd_ff.manual_mode   <= lvl.mode_select_in;        // [R9]
         cmd_ff.target        <= start_ok ? lvl.cmd_pos : target_ff;
      end
   end

   // plc status outputs, all registered
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         zone_flag_out    <= 1'b0;
         mode_status_out  <= 1'b0;
         ready_out        <= 1'b0;
         estop_n_out      <= 1'b1;
         load_judge_out   <= 1'b0;
         torque_level_out <= 1'b0;
         moving_out       <= 1'b0;
      end else begin
         zone_flag_out    <= (zone_armed_ff || start_ok)
                             && core_sts.in_zone;           // [R12]
         mode_status_out  <= lvl.mode_select_in;            // [R13]
         ready_out        <= able;                          // [R16]
         estop_n_out      <= !core_sts.estop;               // [R17]
         load_judge_out   <= ctrl_ff.load_en && core_sts.torque_over
                             && core_sts.in_check;          // [R19]
         torque_level_out <= ctrl_ff.trq_en && core_sts.current_hit; // [R20]
         moving_out       <= core_sts.moving;               // [R21]
      end
   end

   assign core_cmd        = cmd_ff;
   assign done_pos_out    = done_ff;
   assign home_done_out   = home_done_ff;
   assign in_position_out = in_pos_ff;

   // checks on the handshake
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   a_start_edge_once: assert property (                     // [R22]
      start_ok |-> $past(plc_in.motion_start_in, 2)
                   && !$past(plc_in.motion_start_in, 3))
      else $error("start taken without a settled rising edge");
   a_move_request: assert property (                        // [R3]
      start_ok |=> core_cmd.move_req
                   && core_cmd.target == $past(lvl.cmd_pos)
                   ##1 !core_cmd.move_req)
      else $error("move request not a single pulse");
   a_home_request: assert property (                        // [R4]
      home_ok && !start_ok && !core_sts.alarm_raise
      |=> core_cmd.home_req && state_ff == PPIO_HOME)
      else $error("home request missing");
   a_alarm_clear: assert property (                         // [R5]
      rise.alarm_clear_in && !core_sts.alarm_raise
      |=> alarm_n_out && core_cmd.alarm_reset)
      else $error("alarm not cleared by clear edge");
   a_servo_follow: assert property (                        // [R6]
      core_cmd.servo_on == $past(lvl.servo_enable_in))
      else $error("servo level does not follow enable");
   a_pause_stop: assert property (                          // [R7]
      $fell(lvl.pause_n_in) |-> !start_ok ##1 core_cmd.decel_stop)
      else $error("pause did not request a stop");
   a_done_value: assert property (                          // [R10]
      move_done && !start_ok |=> done_pos_out == $past(target_ff)
                                 && in_position_out)
      else $error("completed code wrong");
   a_done_clear: assert property (                          // [R11]
      start_ok |=> done_pos_out == `PPIO_POS_RST && !in_position_out)
      else $error("completed code not cleared at start");
   a_zone_gate: assert property (                           // [R12]
      zone_flag_out |-> zone_armed_ff && $past(core_sts.in_zone))
      else $error("zone flag before any move");
   a_mode_status: assert property (                         // [R13]
      mode_status_out == $past(lvl.mode_select_in))
      else $error("mode status wrong");
   a_home_done_src: assert property (                       // [R14]
      $rose(home_done_out) |-> $past(state_ff) == PPIO_HOME)
      else $error("home done without home return");
   a_ready_level: assert property (                         // [R16]
      ready_out == $past(lvl.servo_enable_in && core_sts.ctrl_ok
                         && !alarm_ff))
      else $error("ready level wrong");
   a_alarm_wins: assert property (                          // [R18]
      core_sts.alarm_raise |=> !alarm_n_out ##1 state_ff == PPIO_IDLE)
      else $error("raised alarm not shown");
   c_move_done: cover property (start_ok ##[1:50] move_done);
   c_home_done: cover property (home_ok ##[1:50] home_fin);
   c_alarm_cycle: cover property (!alarm_n_out ##[1:50] alarm_n_out);
   c_setup_slip: cover property ($rose(setup_viol_ff));

endmodule

// File: ppio_core_model.sv
module ppio_core_model
   import ppio_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              nrst,
   input  wire ppio_core_cmd_type cmd,
   input  wire ppio_core_sts_type ext,
   output ppio_core_sts_type      sts,
   output logic [7:0]             n_moves
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [3:0] move_ff;  // travel cycles still to go
   logic       done_ff;  // parked on the last target
   logic [2:0] home_ff;  // homing cycles still to go
   logic [7:0] moves_ff; // move requests seen

   // travel takes ten cycles; a retarget restarts the count
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         move_ff <= 4'h0;
         done_ff <= 1'b0;
         moves_ff <= 8'h00;
      end else if (cmd.move_req) begin
         move_ff <= 4'hA;
         done_ff <= 1'b0;
         moves_ff <= moves_ff + 8'h01;
      end else if (move_ff != 4'h0) begin
         move_ff <= move_ff - 4'h1;
         done_ff <= (move_ff == 4'h1);
      end
   end

   // homing finishes six cycles after the request
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         home_ff <= 3'h0;
      end else if (cmd.home_req) begin
         home_ff <= 3'h6;
      end else if (home_ff != 3'h0) begin
         home_ff <= home_ff - 3'h1;
      end
   end

   // motion flags come from here, everything else from the bench
   always_comb begin
      sts = ext;
      sts.moving = (move_ff != 4'h0);
      sts.reached = done_ff;
      sts.in_band = done_ff;
      sts.home_finished = (home_ff == 3'h1);
   end

   assign n_moves = moves_ff;
endmodule

// File: positioner_parallel_io_256pt_bench.sv
module positioner_parallel_io_256pt_bench
   import ppio_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic              clk = 1'b0;
   logic              nrst = 1'b0;
   ppio_plc_in_type   plc = '0;       // plc pins
   ppio_core_sts_type ext = '0;       // core flags set by the bench
   ppio_core_sts_type sts;
   ppio_core_cmd_type cmd;
   logic [3:0]        reg_addr = 4'h0;
   logic [31:0]       reg_wdata = 32'h0000_0000;
   logic              reg_wr = 1'b0;
   logic              reg_rd = 1'b0;
   logic [31:0]       rdata;
   logic [31:0]       v;              // last read word
   ppio_code_type     done_pos;
   logic              zone, mode_s, home_d, in_pos, ready;
   logic              estop_n, alarm_n, load_j, trq, moving;
   logic [7:0]        n_moves;
   int                n_errors = 0;
   int                samples_checked = 0;
   int                cycles = 0;

   always #2 clk = ~clk;

   ppio_positioner #(.SETUP_CYCLES(20)) ppio_positioner_inst (
      .clk(clk), .nrst(nrst), .plc_in(plc), .core_sts(sts),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(rdata), .core_cmd(cmd),
      .done_pos_out(done_pos), .zone_flag_out(zone),
      .mode_status_out(mode_s), .home_done_out(home_d),
      .in_position_out(in_pos), .ready_out(ready),
      .estop_n_out(estop_n), .alarm_n_out(alarm_n),
      .load_judge_out(load_j), .torque_level_out(trq),
      .moving_out(moving));

   ppio_core_model ppio_core_model_inst (
      .clk(clk), .nrst(nrst), .cmd(cmd), .ext(ext), .sts(sts),
      .n_moves(n_moves));

   task results;
      if (n_errors == 0 && samples_checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // hang guard, generous against under three hundred cycles of tests
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         n_errors++;
         $display("ERROR %0t: run did not finish", $time);
         results();
      end
   end

   task chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // pins need three edges; six leaves margin for the core reaction
   task settle;
      repeat (6) @(posedge clk);
      #1;
   endtask

   task wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask

   // data stand only in the cycle after the strobe
   task rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 d = rdata;
   endtask

   // start held high until one cycle after in-position: one move only
   // lead: cycles the code stands before start; 0 with a changed code makes a setup slip
   task move(input logic [7:0] code, input int lead);
      int i;
      @(posedge clk);
      plc.cmd_pos <= code;
      repeat (lead) @(posedge clk);           // setup time
      plc.motion_start_in <= 1'b1;
      settle;
      chk(done_pos, 32'h0000_0000);
      chk(moving, 32'h0000_0001);
      chk(cmd.target, code);
      i = 0;
      while (in_pos !== 1'b1 && i < 100) begin
         @(posedge clk);
         #1 i++;
      end
      chk(done_pos, code);
      chk(in_pos, 32'h0000_0001);
      chk(moving, 32'h0000_0000);
      @(posedge clk);
      plc.motion_start_in <= 1'b0;
   endtask

   initial begin
      ext.ctrl_ok <= 1'b1;
      repeat (11) @(posedge clk);
      #1 chk(estop_n, 32'h0000_0001);
      chk(alarm_n, 32'h0000_0001);
      chk(home_d, 32'h0000_0000);
      @(posedge clk);
      nrst <= 1'b1;
      // level pins both ways; ends servo on, running, auto
      for (int k = 0; k < 2; k++) begin
         @(posedge clk);
         plc.servo_enable_in <= k[0];
         plc.pause_n_in <= k[0];
         plc.brake_release_in <= !k[0];
         plc.mode_select_in <= !k[0];
         settle;
         chk(cmd.servo_on, k[0]);
         chk(cmd.decel_stop, !k[0]);
         chk(cmd.brake_release, !k[0]);
         chk(cmd.manual_mode, !k[0]);
         chk(mode_s, !k[0]);
         chk(ready, k[0]);
      end
      @(posedge clk);
      ext.estop <= 1'b1;
      settle;
      chk(estop_n, 32'h0000_0000);
      @(posedge clk);
      ext.estop <= 1'b0;
      ext.in_zone <= 1'b1;
      settle;
      chk(estop_n, 32'h0000_0001);
      chk(zone, 32'h0000_0000);
      move(8'h01, 25);
      chk(zone, 32'h0000_0001);
      @(posedge clk);
      ext.in_zone <= 1'b0;
      settle;
      chk(zone, 32'h0000_0000);
      move(8'h80, 25);
      move(8'hA5, 25);
      chk(n_moves, 32'h0000_0003);
      // pause forces a stop and refuses a start edge
      @(posedge clk);
      plc.pause_n_in <= 1'b0;
      settle;
      chk(cmd.decel_stop, 32'h0000_0001);
      @(posedge clk);
      plc.motion_start_in <= 1'b1;
      settle;
      chk(n_moves, 32'h0000_0003);
      chk(done_pos, 32'h0000_00A5);
      @(posedge clk);
      plc.motion_start_in <= 1'b0;
      plc.pause_n_in <= 1'b1;
      rd(4'h8, v);
      chk(v, 32'h0000_A5A5);
      rd(4'hC, v);
      chk(v, 32'h0000_0000);
      @(posedge clk);
      plc.home_in <= 1'b1;
      settle;
      settle;
      chk(home_d, 32'h0000_0001);
      @(posedge clk);
      plc.home_in <= 1'b0;
      ext.alarm_raise <= 1'b1;
      settle;
      chk(alarm_n, 32'h0000_0000);
      chk(ready, 32'h0000_0000);
      @(posedge clk);
      ext.alarm_raise <= 1'b0;
      plc.alarm_clear_in <= 1'b1;
      settle;
      chk(alarm_n, 32'h0000_0001);
      @(posedge clk);
      plc.alarm_clear_in <= 1'b0;
      ext.torque_over <= 1'b1;
      ext.in_check <= 1'b1;
      ext.current_hit <= 1'b1;
      settle;
      chk(load_j, 32'h0000_0000);
      chk(trq, 32'h0000_0000);
      wr(4'h0, 32'h0000_0003);
      rd(4'h0, v);
      chk(v, 32'h0000_0003);
      settle;
      chk(load_j, 32'h0000_0001);
      chk(trq, 32'h0000_0001);
      @(posedge clk);
      ext.in_check <= 1'b0;
      settle;
      chk(load_j, 32'h0000_0000);
      // code and start together: move runs, slip is logged
      move(8'h3C, 0);
      rd(4'h4, v);
      chk(v, 32'h0000_0174);
      wr(4'h4, 32'h0000_0100);
      rd(4'h4, v);
      chk(v, 32'h0000_0074);
      results();
   end
endmodule
